// ===== ccseq_pkg.sv
// Purpose: Shared constants and types for the core cycle sequencer.
// Assumes: 50 MHz pclk; one 100 ns interval is five pclk cycles.
// Notes:   Register offsets are byte addresses on a 32-bit APB bus.
package ccseq_pkg;

  // Timing of one request interval and its phase slots.
  localparam int CLK_PERIOD_NS = 20;
  localparam int INTERVAL_NS = 100;
  localparam int PH_CYCLES = (INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] PH_LAST = 3'(PH_CYCLES - 1);
  localparam logic [2:0] PH_SEQ = 3'h0;
  localparam logic [2:0] PH_OUT = 3'h1;
  localparam logic [2:0] PH_OUT_DLY = 3'h2;
  localparam logic [2:0] PH_IN = 3'h3;
  localparam logic [2:0] PH_RDATA = 3'h4;

  // Core cycle interval numbers.
  localparam logic [3:0] IV_FIRST_READ = 4'h3;
  localparam logic [3:0] IV_SECOND_READ = 4'h4;
  localparam logic [3:0] IV_LAST = 4'h9;

  // Register offsets.
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_ADDR = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;

  // Control register fields.
  localparam int CTRL_GO = 0;
  localparam int CTRL_ST_UPPER = 1;
  localparam int CTRL_ST_LOWER = 2;
  localparam int CTRL_RD_EN = 3;
  localparam int CTRL_RD_UPPER = 4;
  localparam int ADDR_W = 14;

  // Reset values.
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0000;
  localparam logic [3:0] IV_RESET = 4'h9;

  // Request captured for a core cycle: resident and current status view.
  typedef struct packed {
    logic st_upper;
    logic st_lower;
    logic rd_en;
    logic rd_upper;
  } ccseq_req_t;

  // Commands driven to the core module.
  typedef struct packed {
    logic start;
    logic upper_half_store_cmd;
    logic lower_half_store_cmd;
    logic read_cmd;
    logic read_half_select_cmd;
    logic core_output_strobe;
    logic reg_input_strobe;
  } ccseq_core_cmd_t;

  // Answers driven to the requesting port.
  typedef struct packed {
    logic first_resp;
    logic accepted;
    logic satisfied;
    logic not_satisfied_resp;
    logic reg_input_strobe;
    logic port_output_strobe;
  } ccseq_port_resp_t;

endpackage

// ===== ccseq_core_cycle_sequencer.sv
// Purpose: Steps a core memory cycle through 100 ns intervals and shares
//          the buffer register buses between the ports and the core.
// Assumes: APB slave with zero wait states; port and core inputs are
//          asynchronous pins and are synchronised before use.
// Notes:   The five phase clocks are one-cycle slots inside each interval.
//
// Summary of operation
// - Each 100 ns interval splits into sequence, out, out delay, in and read data phase slots.
// - First port response after in phase; second response on out phase.
// - Store input strobe within 100 ns; output strobe with the response.
// - Inhibits suppress second responses and port strobes after first one.
// - Interval counter advances on sequence phase; core events follow it.
// - Core address valid before start; start pulse sent in interval 0.
// - Upper then lower store commands in intervals 0 and 1 as needed.
// - Each store interval raises fetch inhibit; port fetches not satisfied.
// - Each core read interval raises store inhibit, blocking port stores.
// - Store command originates in the available interval before start.
// - Register-to-core start gives output strobe on out phase, then store.
// - Read half-select is prepared ahead of the read data intervals.
// - Interval 0 held in its own flop while the counter is cleared.
// - Cycle starts by latching status on sequence phase while available.
// - Status makes register-to-core start, fetch inhibit, strobe, command.
// - Separate upper and lower store lines; one read half-select bit.
// - Second word store in second slot; interval 0 clears free and sync.
// - Second write re-derives start from latest status, lower store.
// - Interval 2 generates no new core signals; interval 1 only the second word store.
// - Read time gives core-to-register start, store inhibit, read command.
// - Core read capture strobe waits for in phase of next interval.
// - Ports free after reads; module busy until interval 9 availability.
// - Core cycle spans ten intervals 0 to 9 at the request rate.
`timescale 1ns/10ps
module ccseq_core_cycle_sequencer (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port request pins.
  input wire logic port_req,
  input wire logic port_req_store,
  output ccseq_pkg::ccseq_port_resp_t port_resp,
  // Core module pins.
  input wire logic unit_available,
  output ccseq_pkg::ccseq_core_cmd_t core_cmd,
  output logic [ccseq_pkg::ADDR_W-1:0] core_addr_bits,
  // Bus sharing conditions.
  output logic store_inhibit,
  output logic fetch_inhibit
);

  // Phase slot counter and the phase strobes it decodes.
  logic [2:0] ph_q;
  logic seq_phase_clk;
  logic out_phase_clk;
  logic out_dly_clk;
  logic in_phase_clk;
  logic read_data_clk;

  // Synchronisers for the asynchronous pins.
  logic [1:0] ua_sync_q;
  logic [1:0] req_sync_q;
  logic [1:0] rst_sync_q;
  logic ua_s;
  logic req_s;
  logic req_store_s;

  // Software registers.
  logic [3:0] ctrl_q;
  logic [ccseq_pkg::ADDR_W-1:0] addr_q;
  logic pending_q;

  // Core cycle state.
  logic [3:0] iv_q;
  logic interval0_q;
  logic core_free_flag_q;
  logic unit_avail_sync_q;
  logic in_proc_q;
  ccseq_pkg::ccseq_req_t stat_q;
  logic cycle_go;
  logic reg_to_core_start;
  logic core_to_reg_start;
  logic read_data_time;
  logic rd_prev_q;
  logic core_cmd_half_q;

  // Port service state.
  logic port_open_q;
  logic port_store_q;
  logic store_ok_q;

  // APB decode.
  logic apb_wr;
  logic apb_rd;
  logic addr_hit;

  // True when the offset names a mapped register.
  function automatic logic is_mapped(input logic [11:0] a);
    return (a == ccseq_pkg::OFF_CTRL) || (a == ccseq_pkg::OFF_ADDR) ||
           (a == ccseq_pkg::OFF_STATUS);
  endfunction

  // Phase slots repeat every interval; each clock is one slot wide.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 3'h0;
    end else if (ph_q == ccseq_pkg::PH_LAST) begin
      ph_q <= 3'h0;
    end else begin
      ph_q <= ph_q + 3'h1;
    end
  end

  // Phase decodes.
  assign seq_phase_clk = (ph_q == ccseq_pkg::PH_SEQ);
  assign out_phase_clk = (ph_q == ccseq_pkg::PH_OUT);
  assign out_dly_clk = (ph_q == ccseq_pkg::PH_OUT_DLY);
  assign in_phase_clk = (ph_q == ccseq_pkg::PH_IN);
  assign read_data_clk = (ph_q == ccseq_pkg::PH_RDATA);

  // Two-flop synchronisers; only the second stage is read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ua_sync_q <= 2'h0;
      req_sync_q <= 2'h0;
      rst_sync_q <= 2'h0;
    end else begin
      ua_sync_q <= {ua_sync_q[0], unit_available};
      req_sync_q <= {req_sync_q[0], port_req};
      rst_sync_q <= {rst_sync_q[0], port_req_store};
    end
  end

  assign ua_s = ua_sync_q[1];
  assign req_s = req_sync_q[1];
  assign req_store_s = rst_sync_q[1];

  // APB: zero wait state; unmapped offsets answer with an error.
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;
  assign addr_hit = is_mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  // Control and address registers; go is a self-clearing command bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ccseq_pkg::CTRL_RESET;
      addr_q <= ccseq_pkg::ADDR_RESET;
    end else if (apb_wr && paddr == ccseq_pkg::OFF_CTRL) begin
      ctrl_q <= pwdata[ccseq_pkg::CTRL_RD_UPPER:ccseq_pkg::CTRL_ST_UPPER];
    end else if (apb_wr && paddr == ccseq_pkg::OFF_ADDR && !in_proc_q) begin
      addr_q <= pwdata[ccseq_pkg::ADDR_W-1:0];
    end
  end

  // Pending cycle request; a new go in the start cycle is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_q <= 1'b0;
    end else if (apb_wr && paddr == ccseq_pkg::OFF_CTRL &&
                 pwdata[ccseq_pkg::CTRL_GO]) begin
      pending_q <= 1'b1;
    end else if (cycle_go) begin
      pending_q <= 1'b0;
    end
  end

  // Read data is registered in the setup phase so it is stable in access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd && !penable) begin
      case (paddr)
        ccseq_pkg::OFF_CTRL: prdata <= {27'h0, ctrl_q, 1'b0};
        ccseq_pkg::OFF_ADDR: prdata <= {18'h0, addr_q};
        ccseq_pkg::OFF_STATUS: prdata <= {20'h0, fetch_inhibit,
          store_inhibit, pending_q, in_proc_q, unit_avail_sync_q,
          core_free_flag_q, interval0_q, 1'b0, iv_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // A cycle starts on the sequence slot while the module is available.
  assign cycle_go = seq_phase_clk && pending_q && unit_avail_sync_q &&
                    core_free_flag_q && !in_proc_q;

  // Availability sync and core-free flag; start clears both.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_avail_sync_q <= 1'b1;
      core_free_flag_q <= 1'b1;
    end else if (cycle_go) begin
      unit_avail_sync_q <= 1'b0;
      core_free_flag_q <= 1'b0;
    end else if (seq_phase_clk && ua_s && iv_q == ccseq_pkg::IV_LAST) begin
      unit_avail_sync_q <= 1'b1;
      core_free_flag_q <= 1'b1;
    end
  end

  // Interval counter: cleared at start, advances per interval, holds at 9.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iv_q <= ccseq_pkg::IV_RESET;
    end else if (cycle_go) begin
      iv_q <= 4'h0;
    end else if (seq_phase_clk && iv_q != ccseq_pkg::IV_LAST) begin
      iv_q <= iv_q + 4'h1;
    end
  end

  // Interval 0 runs in its own flop so it is decoded without counter lag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval0_q <= 1'b0;
    end else if (cycle_go) begin
      interval0_q <= 1'b1;
    end else if (seq_phase_clk) begin
      interval0_q <= 1'b0;
    end
  end

  // In-process state and the status latched at the start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_proc_q <= 1'b0;
      stat_q <= '0;
      core_addr_bits <= ccseq_pkg::ADDR_RESET;
    end else if (cycle_go) begin
      in_proc_q <= 1'b1;
      // The control word holds upper store in its low bit, so map by name.
      stat_q.st_upper <= ctrl_q[0];
      stat_q.st_lower <= ctrl_q[1];
      stat_q.rd_en <= ctrl_q[2];
      stat_q.rd_upper <= ctrl_q[3];
      core_addr_bits <= addr_q;
    end else if (seq_phase_clk && iv_q == ccseq_pkg::IV_LAST) begin
      in_proc_q <= 1'b0;
    end else if (seq_phase_clk && iv_q == 4'h0) begin
      stat_q <= {stat_q.st_upper, stat_q.st_lower & ctrl_q[1],
                 stat_q.rd_en, stat_q.rd_upper};
    end
  end

  // Register-to-core start: interval 0 for either half, interval 1 for the
  // second word of a double store. Intervals 1 and 2 carry nothing else.
  assign reg_to_core_start = in_proc_q &&
    ((interval0_q && (stat_q.st_upper || stat_q.st_lower)) ||
     (!interval0_q && iv_q == 4'h1 && stat_q.st_upper &&
      stat_q.st_lower));

  // Read time covers the two core read intervals.
  assign read_data_time = in_proc_q && stat_q.rd_en && !interval0_q &&
    (iv_q == ccseq_pkg::IV_FIRST_READ ||
     iv_q == ccseq_pkg::IV_SECOND_READ);
  assign core_to_reg_start = read_data_time;

  // Inhibits follow the core's use of the register buses.
  assign fetch_inhibit = reg_to_core_start;
  assign store_inhibit = core_to_reg_start;

  // Read time of the previous interval, for the delayed capture strobe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_prev_q <= 1'b0;
    end else if (seq_phase_clk) begin
      rd_prev_q <= read_data_time;
    end
  end

  // Core-side commands; each is registered, and all but the half select last one phase slot.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_cmd <= '0;
    end else begin
      core_cmd.start <= in_proc_q && interval0_q && out_phase_clk;
      core_cmd.core_output_strobe <= out_phase_clk &&
                                     reg_to_core_start;
      core_cmd.upper_half_store_cmd <= out_dly_clk && reg_to_core_start &&
        interval0_q && stat_q.st_upper;
      core_cmd.lower_half_store_cmd <= out_dly_clk && reg_to_core_start &&
        (!interval0_q || !stat_q.st_upper);
      core_cmd.read_cmd <= read_data_clk && read_data_time;
      core_cmd.reg_input_strobe <= in_phase_clk && rd_prev_q;
      core_cmd.read_half_select_cmd <= core_cmd_half_q;
    end
  end

  // The half select is set up from the start so it is ready for read data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_cmd_half_q <= 1'b0;
    end else if (cycle_go) begin
      core_cmd_half_q <= ctrl_q[3];
    end
  end

  // Port service: a request is taken on the in phase slot and answered on
  // the next out phase slot, so an inhibit raised in between still counts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_open_q <= 1'b0;
      port_store_q <= 1'b0;
    end else if (in_phase_clk) begin
      port_open_q <= req_s;
      port_store_q <= req_store_s;
    end else if (out_phase_clk) begin
      port_open_q <= 1'b0;
    end
  end

  // An accepted store gets its input strobe on the next in phase slot,
  // which puts it exactly one interval after the first response.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_ok_q <= 1'b0;
    end else if (out_phase_clk) begin
      store_ok_q <= port_open_q && port_store_q && !store_inhibit;
    end else if (in_phase_clk) begin
      store_ok_q <= 1'b0;
    end
  end

  // Port responses are registered; each lasts one phase slot.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_resp <= '0;
    end else begin
      port_resp.first_resp <= in_phase_clk && req_s;
      port_resp.accepted <= out_phase_clk && port_open_q &&
                            port_store_q && !store_inhibit;
      port_resp.satisfied <= out_phase_clk && port_open_q &&
                             !port_store_q && !fetch_inhibit;
      port_resp.not_satisfied_resp <= out_phase_clk && port_open_q &&
                                      !port_store_q && fetch_inhibit;
      port_resp.port_output_strobe <= out_phase_clk && port_open_q &&
                                      !port_store_q && !fetch_inhibit;
      port_resp.reg_input_strobe <= in_phase_clk && store_ok_q;
    end
  end

endmodule

// ===== ccseq_props.sv
// Purpose: Concurrent checks on the core cycle sequencer outputs.
// Assumes: A counter of cycles since the last start pulse.
// Notes: Bound into every sequencer instance.
`timescale 1ns/10ps
module ccseq_props (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Watched outputs.
  input wire ccseq_pkg::ccseq_port_resp_t port_resp,
  input wire ccseq_pkg::ccseq_core_cmd_t core_cmd,
  input wire logic [ccseq_pkg::ADDR_W-1:0] core_addr_bits,
  input wire logic store_inhibit,
  input wire logic fetch_inhibit
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [7:0] age_q;
  logic seen_q;
  logic st_any;
  assign st_any = core_cmd.upper_half_store_cmd |
    core_cmd.lower_half_store_cmd;
  // The age saturates so a long idle gap never wraps into a window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= 8'hff;
      seen_q <= 1'b0;
    end else if (core_cmd.start) begin
      age_q <= 8'h00;
      seen_q <= 1'b1;
    end else if (age_q != 8'hff) begin
      age_q <= age_q + 8'h01;
    end
  end
  start_gap_a: assert property (
    $rose(core_cmd.start) && seen_q |-> age_q >= 8'd40)
    else $error("core cycles started too close");
  start_short_a: assert property (
    core_cmd.start |-> ##[1:5] !core_cmd.start)
    else $error("start pulse too long");
  addr_stable_a: assert property (
    $rose(core_cmd.start) |-> $stable(core_addr_bits))
    else $error("core address moved at start");
  store_win_a: assert property (
    st_any |-> core_cmd.start || age_q <= 8'd14)
    else $error("store command outside first intervals");
  read_win_a: assert property (
    core_cmd.read_cmd |-> age_q inside {[8'd5:8'd30]})
    else $error("read command outside read time");
  inh_excl_a: assert property (
    !(store_inhibit && fetch_inhibit))
    else $error("both inhibits at once");
  store_fi_a: assert property (
    st_any |-> fetch_inhibit)
    else $error("store command without fetch inhibit");
  read_si_a: assert property (
    core_cmd.read_cmd |-> store_inhibit)
    else $error("read command without store inhibit");
  core_output_strobe_fi_a: assert property (
    core_cmd.core_output_strobe |-> fetch_inhibit)
    else $error("core strobe without fetch inhibit");
  start_c: cover property (core_cmd.start);
  read_c: cover property (core_cmd.read_cmd);
  not_satisfied_resp_c: cover property (port_resp.not_satisfied_resp);
endmodule
bind ccseq_core_cycle_sequencer ccseq_props i_props (.pclk(pclk),
  .presetn(presetn), .port_resp(port_resp), .core_cmd(core_cmd),
  .core_addr_bits(core_addr_bits), .store_inhibit(store_inhibit),
  .fetch_inhibit(fetch_inhibit));

// ===== ccseq_core_model.sv
// Purpose: Behavioural core memory module facing the sequencer.
// Assumes: Busy time counted in pclk cycles after start.
// Notes: Slow mode doubles the busy time.
`timescale 1ns/10ps
module ccseq_core_model #(
  parameter int DROP_CYC = 3,
  parameter int BUSY_CYC = 40
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Core side.
  input wire ccseq_pkg::ccseq_core_cmd_t core_cmd,
  input wire logic slow,
  output logic unit_available
);
  int cnt;
  // Unavailable shortly after start, back near the end of the cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      unit_available <= 1'b1;
    end else if (cnt == 0) begin
      if (core_cmd.start) cnt <= 1;
    end else begin
      cnt <= cnt + 1;
      if (cnt == DROP_CYC) unit_available <= 1'b0;
      if (cnt == (slow ? 2 * BUSY_CYC : BUSY_CYC)) begin
        unit_available <= 1'b1;
        cnt <= 0;
      end
    end
  end
endmodule

// ===== tb_top.sv
// Purpose: Self-checking bench for the core cycle sequencer.
// Assumes: The core model answers on unit_available.
// Notes: Each scenario task judges its own outcome.
`timescale 1ns/10ps
module tb_top;
  localparam logic [31:0] GO = 32'h1 << ccseq_pkg::CTRL_GO;
  localparam logic [31:0] UP = 32'h1 << ccseq_pkg::CTRL_ST_UPPER;
  localparam logic [31:0] LO = 32'h1 << ccseq_pkg::CTRL_ST_LOWER;
  localparam logic [31:0] RD = 32'h1 << ccseq_pkg::CTRL_RD_EN;
  localparam logic [31:0] RU = 32'h1 << ccseq_pkg::CTRL_RD_UPPER;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic port_req = 1'b0;
  logic port_req_store = 1'b0;
  logic slow = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, unit_available, store_inhibit, fetch_inhibit;
  ccseq_pkg::ccseq_port_resp_t port_resp;
  ccseq_pkg::ccseq_core_cmd_t core_cmd;
  logic [ccseq_pkg::ADDR_W-1:0] core_addr_bits, a_seen;
  int error_cnt = 0;
  int n_checks = 0;
  int t[5];
  logic s_sel, s_si, s_not_satisfied_resp;
  // Clock at 50 MHz.
  always #10 pclk = ~pclk;
  ccseq_core_cycle_sequencer i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .port_req,
    .port_req_store, .port_resp, .unit_available, .core_cmd,
    .core_addr_bits, .store_inhibit, .fetch_inhibit);
  ccseq_core_model i_core (.pclk, .presetn, .core_cmd, .slow,
    .unit_available);
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      error_cnt++;
      $display("MISMATCH %0t bus wait ran out", $time);
      wrap_up();
    end
  endtask
  // Starts a core cycle and records when start, each store command and the read command first show.
  task automatic run(input logic [31:0] c, input logic pr,
      input logic ps, input logic tw);
    logic [31:0] q;
    logic prev;
    t = '{default: -1};
    s_sel = 1'bx;
    s_si = 1'b0;
    s_not_satisfied_resp = 1'b0;
    prev = 1'b0;
    apb(1'b1, ccseq_pkg::OFF_CTRL, c, q);
    if (tw) apb(1'b1, ccseq_pkg::OFF_CTRL, c, q);
    port_req <= pr;
    port_req_store <= ps;
    for (int i = 0; i < 200; i++) begin
      @(posedge pclk);
      #1;
      if (core_cmd.start && !prev && t[0] >= 0 && t[1] < 0) t[1] = i;
      if (core_cmd.start && t[0] < 0) begin
        t[0] = i;
        a_seen = core_addr_bits;
      end
      if (core_cmd.upper_half_store_cmd && t[2] < 0) t[2] = i;
      if (core_cmd.lower_half_store_cmd && t[3] < 0) t[3] = i;
      if (core_cmd.read_cmd && t[4] < 0) begin
        t[4] = i;
        s_sel = core_cmd.read_half_select_cmd;
      end
      if (store_inhibit) s_si = 1'b1;
      if (port_resp.not_satisfied_resp) s_not_satisfied_resp = 1'b1;
      prev = core_cmd.start;
    end
    port_req <= 1'b0;
    apb(1'b1, ccseq_pkg::OFF_CTRL, 32'h0, q);
    repeat (100) @(posedge pclk);
  endtask
  task automatic t_reset();
    logic [31:0] q;
    apb(1'b0, ccseq_pkg::OFF_CTRL, 32'h0, q);
    chk(32'(q[3:0]), 32'(ccseq_pkg::CTRL_RESET), "ctrl reset");
    apb(1'b0, ccseq_pkg::OFF_ADDR, 32'h0, q);
    chk(32'(q[13:0]), 32'(ccseq_pkg::ADDR_RESET), "addr reset");
    apb(1'b0, 12'hffc, 32'h0, q);
    $display("Test reset done");
  endtask
  task automatic t_dbl();
    logic [31:0] q;
    apb(1'b1, ccseq_pkg::OFF_ADDR, 32'h00002a5c, q);
    run(GO | UP | LO, 1'b1, 1'b0, 1'b0);
    chk(32'(t[0] >= 0), 32'h1, "start seen");
    chk(32'(a_seen), 32'h2a5c, "core address");
    chk(32'(t[2] >= t[0] && t[3] > t[2]), 32'h1, "upper then lower");
    chk(32'(t[3] - t[0] <= 10), 32'h1, "stores early");
    chk(32'(s_not_satisfied_resp), 32'h1, "fetch refused");
    run(GO | LO, 1'b0, 1'b0, 1'b0);
    chk(32'(t[2] < 0 && t[3] >= 0), 32'h1, "lower only");
    run(GO | UP, 1'b0, 1'b0, 1'b0);
    chk(32'(t[3] < 0 && t[2] >= 0), 32'h1, "upper only");
    $display("Test store done");
  endtask
  task automatic t_read();
    for (int k = 0; k < 2; k++) begin
      run(GO | RD | (k ? RU : 32'h0), 1'b1, 1'b1, 1'b0);
      chk(32'(s_sel), 32'(k), "half select");
      chk(32'(s_si), 32'h1, "store blocked");
      chk(32'(t[4] - t[0] inside {[10:25]}), 32'h1, "read time");
      chk(32'(t[2] < 0 && t[3] < 0), 32'h1, "no store");
    end
    $display("Test read done");
  endtask
  task automatic t_gap();
    run(GO | UP, 1'b0, 1'b0, 1'b1);
    chk(32'(t[1] < 0 || t[1] - t[0] >= 50), 32'h1, "cycle length");
    slow <= 1'b1;
    run(GO | UP, 1'b0, 1'b0, 1'b1);
    slow <= 1'b0;
    chk(32'(t[1] < 0 || t[1] - t[0] >= 80), 32'h1, "unit wait");
    $display("Test gap done");
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_dbl();
    t_read();
    t_gap();
    wrap_up();
  end
endmodule
